// File: include/store_unit_pkg.sv
package store_unit_pkg;

  // opcode fields
  localparam logic [3:0] OP_WORD_TOP   = 4'hC;
  localparam logic [7:0] OP_BYTE_TOP   = 8'hE5;
  localparam logic [1:0] OP_BYTE_SUB   = 2'h1;
  localparam int         WORD_LEN_BITS = 16;
  localparam int         BYTE_LEN_BITS = 24;

  // memory-mapped register window: addresses below this are registers
  localparam logic [22:0] REG_WINDOW_LIMIT = 23'h000060;

  // reset values
  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam logic [22:0] ADDR_RST = 23'h000000;

  typedef enum logic [1:0] {
    ST_WORD = 2'b00,
    ST_HIGH = 2'b01,
    ST_LOW  = 2'b10,
    ST_NONE = 2'b11
  } store_kind_e;

  // one write request on the data memory write bus
  typedef struct packed {
    logic        valid;
    logic [22:0] addr;
    logic [15:0] data;
    logic [1:0]  byte_en;
  } mem_write_s;

endpackage

// File: rtl/register_to_memory_store_unit.sv
`timescale 1ns/1ps

// Operation
// [RULE1] word-store opcode writes selected register to the addressed data word
// [RULE2] accumulator word store writes only bits 15..0
// [RULE3] aux or temp word store writes the full 16-bit register
// [RULE4] private store path; no data-unit or address-unit arithmetic used
// [RULE5] high-byte store puts source bits 7..0 in word bits 15..8
// [RULE6] low-byte store puts source bits 7..0 in word bits 7..0
// [RULE7] aux or temp byte stores take register bits 7..0
// [RULE8] byte store to memory-mapped register: no write, raise bus fault request
// [RULE9] works under repeat, one store per iteration; no status bits touched
// [RULE10] F/SSS pick source, address field gives address, one execute cycle
module register_to_memory_store_unit (
  // clock and reset
  input  wire logic                       clk_in,
  input  wire logic                       arst_n_in,
  // decoded instruction, left aligned
  input  wire logic                       instr_valid_in,
  input  wire logic [23:0]                instr_in,
  input  wire logic [22:0]                addr_in,
  // register file views
  input  wire logic [39:0]                acc_in [4],
  input  wire logic [15:0]                aux_in [8],
  input  wire logic [15:0]                tmp_in [4],
  // data memory write bus
  output store_unit_pkg::mem_write_s      mem_wr_out,
  // bus-error interrupt request, high for one cycle per refused byte store
  output logic                            bus_fault_irq_out
);

  store_unit_pkg::store_kind_e kind;
  logic                        f_bit;
  logic [2:0]                  sss;
  logic [15:0]                 src_value;
  logic                        in_reg_window;
  store_unit_pkg::mem_write_s  wr_next;
  store_unit_pkg::mem_write_s  wr_reg;
  logic                        fault_reg;

  function automatic store_unit_pkg::store_kind_e decode_kind(input logic [23:0] ins);
    decode_kind = store_unit_pkg::ST_NONE;
    if (ins[23:20] == store_unit_pkg::OP_WORD_TOP)
    begin
      decode_kind = store_unit_pkg::ST_WORD; // [RULE1]
    end
    else if (ins[23:16] == store_unit_pkg::OP_BYTE_TOP && ins[3:2] == store_unit_pkg::OP_BYTE_SUB)
    begin
      decode_kind = ins[0] ? store_unit_pkg::ST_LOW : store_unit_pkg::ST_HIGH;
    end
  endfunction

  assign kind   = decode_kind(instr_in);
  // F/SSS lie in different fields for the two encodings
  assign f_bit  = (kind == store_unit_pkg::ST_WORD) ? instr_in[19] : instr_in[7]; // [RULE10]
  assign sss    = (kind == store_unit_pkg::ST_WORD) ? instr_in[18:16] : instr_in[6:4];
  // fixed window bound: a byte lane inside a register would corrupt its neighbour field
  assign in_reg_window = addr_in < store_unit_pkg::REG_WINDOW_LIMIT;

  // plain mux, no arithmetic: keeps the ALUs and MACs free
  store_src_mux u_src ( // [RULE4]
    .f_bit_in  (f_bit),
    .sss_in    (sss),
    .acc_in    (acc_in),
    .aux_in    (aux_in),
    .tmp_in    (tmp_in),
    .value_out (src_value)
  );

  always_comb
  begin
    wr_next = '0;
    if (instr_valid_in)
    begin
      wr_next.addr = addr_in; // [RULE10]
      unique case (kind)
        store_unit_pkg::ST_WORD:
        begin
          wr_next.valid   = 1'b1; // [RULE1]
          wr_next.data    = src_value;
          wr_next.byte_en = 2'b11;
        end
        store_unit_pkg::ST_HIGH:
        begin
          wr_next.valid   = !in_reg_window; // [RULE8]
          wr_next.data    = {src_value[7:0], 8'h00}; // [RULE5] [RULE7]
          wr_next.byte_en = 2'b10;
        end
        store_unit_pkg::ST_LOW:
        begin
          wr_next.valid   = !in_reg_window; // [RULE8]
          wr_next.data    = {8'h00, src_value[7:0]}; // [RULE6] [RULE7]
          wr_next.byte_en = 2'b01;
        end
        store_unit_pkg::ST_NONE:
        begin
          wr_next.valid = 1'b0;
        end
      endcase
    end
  end

  // every valid cycle is one store, so repeated issue gives one per iteration
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      wr_reg.valid   <= 1'b0;
      wr_reg.addr    <= store_unit_pkg::ADDR_RST;
      wr_reg.data    <= store_unit_pkg::DATA_RST;
      wr_reg.byte_en <= 2'h0;
    end
    else
    begin
      wr_reg <= wr_next; // [RULE9]
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      fault_reg <= 1'b0;
    end
    else
    begin
      fault_reg <= instr_valid_in && in_reg_window && // [RULE8]
                   (kind == store_unit_pkg::ST_HIGH || kind == store_unit_pkg::ST_LOW);
    end
  end

  assign mem_wr_out        = wr_reg;
  assign bus_fault_irq_out = fault_reg;

  a_word_store_data: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [RULE1]
    instr_valid_in && kind == store_unit_pkg::ST_WORD |=>
      mem_wr_out.valid && mem_wr_out.byte_en == 2'b11 && mem_wr_out.addr == $past(addr_in)
      && mem_wr_out.data == $past(src_value))
    else $error("word store not issued");

  a_acc_low_bits: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [RULE2]
    instr_valid_in && kind == store_unit_pkg::ST_WORD && !f_bit |=>
      mem_wr_out.data == $past(acc_in[sss[1:0]][15:0]))
    else $error("accumulator word store data wrong");

  a_high_byte_lane: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [RULE5]
    instr_valid_in && kind == store_unit_pkg::ST_HIGH && !in_reg_window |=>
      mem_wr_out.valid && mem_wr_out.byte_en == 2'b10
      && mem_wr_out.data[15:8] == $past(src_value[7:0]))
    else $error("high byte store wrong");

  a_low_byte_lane: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [RULE6]
    instr_valid_in && kind == store_unit_pkg::ST_LOW && !in_reg_window |=>
      mem_wr_out.valid && mem_wr_out.byte_en == 2'b01
      && mem_wr_out.data[7:0] == $past(src_value[7:0]))
    else $error("low byte store wrong");

  a_window_byte_fault: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [RULE8]
    instr_valid_in && in_reg_window
      && (kind == store_unit_pkg::ST_HIGH || kind == store_unit_pkg::ST_LOW) |=>
      !mem_wr_out.valid && bus_fault_irq_out ##1 (!bus_fault_irq_out || $past(instr_valid_in)))
    else $error("byte store to register window not refused");

  a_no_false_fault: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [RULE8]
    bus_fault_irq_out |-> $past(in_reg_window) && $past(instr_valid_in) && !mem_wr_out.valid
      && ($past(kind) == store_unit_pkg::ST_HIGH || $past(kind) == store_unit_pkg::ST_LOW))
    else $error("spurious bus fault");

  a_repeat_stores: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [RULE9]
    (instr_valid_in && kind == store_unit_pkg::ST_WORD)[*3] |=>
      mem_wr_out.valid && $past(mem_wr_out.valid) && $past(mem_wr_out.valid, 2))
    else $error("repeated store dropped");

  a_repeat_bytes: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [RULE9]
    (instr_valid_in && kind == store_unit_pkg::ST_LOW && !in_reg_window)[*2] |=>
      mem_wr_out.valid && $past(mem_wr_out.valid))
    else $error("repeated byte store dropped");

  a_aux_word_data: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [RULE3]
    instr_valid_in && kind == store_unit_pkg::ST_WORD && f_bit |=>
      mem_wr_out.data == $past(sss[2] ? tmp_in[sss[1:0]] : aux_in[{1'b0, sss[1:0]}]))
    else $error("aux or temp word store data wrong");

  a_acc_high_byte: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [RULE5]
    instr_valid_in && kind == store_unit_pkg::ST_HIGH && !f_bit && !in_reg_window |=>
      mem_wr_out.data == {$past(acc_in[sss[1:0]][7:0]), 8'h00})
    else $error("accumulator high byte store wrong");

  a_acc_low_byte: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [RULE6]
    instr_valid_in && kind == store_unit_pkg::ST_LOW && !f_bit && !in_reg_window |=>
      mem_wr_out.data == {8'h00, $past(acc_in[sss[1:0]][7:0])})
    else $error("accumulator low byte store wrong");

  a_byte_reg_source: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [RULE7]
    instr_valid_in && f_bit && !in_reg_window
      && (kind == store_unit_pkg::ST_HIGH || kind == store_unit_pkg::ST_LOW) |=>
      (mem_wr_out.data[15:8] | mem_wr_out.data[7:0])
      == $past(sss[2] ? tmp_in[sss[1:0]][7:0] : aux_in[{1'b0, sss[1:0]}][7:0]))
    else $error("aux or temp byte store data wrong");

  a_high_form_zero: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [RULE5]
    instr_valid_in && kind == store_unit_pkg::ST_HIGH |=>
      mem_wr_out.data[7:0] == 8'h00)
    else $error("high byte store drives low lane");

  a_low_form_zero: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [RULE6]
    instr_valid_in && kind == store_unit_pkg::ST_LOW |=>
      mem_wr_out.data[15:8] == 8'h00)
    else $error("low byte store drives high lane");

  a_write_address: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [RULE10]
    instr_valid_in && kind != store_unit_pkg::ST_NONE |=>
      mem_wr_out.addr == $past(addr_in))
    else $error("store address wrong");

  a_unknown_ignored: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [RULE1]
    instr_valid_in && kind == store_unit_pkg::ST_NONE |=>
      !mem_wr_out.valid && !bus_fault_irq_out)
    else $error("unknown opcode acted on");

  a_word_no_fault: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [RULE8]
    instr_valid_in && kind == store_unit_pkg::ST_WORD |=>
      !bus_fault_irq_out)
    else $error("word store raised bus fault");

  a_idle_quiet: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [RULE10]
    !instr_valid_in |=> !mem_wr_out.valid && !bus_fault_irq_out)
    else $error("write without instruction");

endmodule

// File: rtl/store_src_mux.sv
`timescale 1ns/1ps

// source register selection: F=0 accumulator, F=1 aux/temp register
module store_src_mux (
  // selection
  input  wire logic        f_bit_in,
  input  wire logic [2:0]  sss_in,
  // register file views
  input  wire logic [39:0] acc_in [4],
  input  wire logic [15:0] aux_in [8],
  input  wire logic [15:0] tmp_in [4],
  // result
  output logic      [15:0] value_out
);

  always_comb
  begin
    if (!f_bit_in)
    begin
      // only bits 15..0 leave the accumulator; guard bits dropped
      value_out = acc_in[sss_in[1:0]][15:0]; // [RULE2]
    end
    else if (!sss_in[2])
    begin
      value_out = aux_in[{1'b0, sss_in[1:0]}]; // [RULE3]
    end
    else
    begin
      value_out = tmp_in[sss_in[1:0]]; // [RULE3]
    end
  end

endmodule

// File: test/data_mem_model.sv
`timescale 1ns/1ps

module data_mem_model (
  // clock
  input  wire logic                       clk_in,
  // write bus from the store unit
  input  wire store_unit_pkg::mem_write_s wr_in,
  // read-back port
  input  wire logic [9:0]                 rd_addr_in,
  output logic      [15:0]                rd_data_out
);
  logic [15:0] mem [1024];

  // lane merge lives here, so a byte store never disturbs its neighbour
  always_ff @(posedge clk_in)
  begin
    if (wr_in.valid && wr_in.byte_en[1])
      mem[wr_in.addr[9:0]][15:8] <= wr_in.data[15:8];
    if (wr_in.valid && wr_in.byte_en[0])
      mem[wr_in.addr[9:0]][7:0] <= wr_in.data[7:0];
  end
  assign rd_data_out = mem[rd_addr_in];
endmodule

// File: test/tb_top.sv
`timescale 1ns/1ps

module tb_top;
  logic                       clk_in;
  logic                       arst_n_in;
  logic                       instr_valid_in;
  logic [23:0]                instr_in;
  logic [22:0]                addr_in;
  logic [39:0]                acc_in [4];
  logic [15:0]                aux_in [8];
  logic [15:0]                tmp_in [4];
  store_unit_pkg::mem_write_s mem_wr_out;
  logic                       bus_fault_irq_out;
  logic [15:0]                rd_data;
  logic [31:0]                lfsr = 32'h535F65BB;
  logic [42:0]                exp_q [$];
  int                         failures = 0;
  int                         n_compared = 0;

  register_to_memory_store_unit i_dut (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .instr_valid_in(instr_valid_in), .instr_in(instr_in), .addr_in(addr_in),
    .acc_in(acc_in), .aux_in(aux_in), .tmp_in(tmp_in), .mem_wr_out(mem_wr_out),
    .bus_fault_irq_out(bus_fault_irq_out));
  data_mem_model i_mem (.clk_in(clk_in), .wr_in(mem_wr_out), .rd_addr_in(10'h200),
    .rd_data_out(rd_data));

  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction

  task automatic check(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'b1)
    begin
      failures++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask

  task automatic test_done();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // kind 0 word, 1 high byte, 2 low byte, 3 unknown opcode
  task automatic store(input logic [1:0] k, input logic [3:0] fs, input logic [22:0] a);
    logic [15:0] s;
    logic [15:0] d;
    logic [23:0] r;
    s = fs[3] ? (fs[2] ? tmp_in[fs[1:0]] : aux_in[fs[1:0]]) : acc_in[fs[1:0]][15:0];
    d = (k == 2'h0) ? s : (k[1] ? {8'h00, s[7:0]} : {s[7:0], 8'h00});
    r = 24'(rnd());
    if (k == 2'h0)
      r[23:16] = {4'hC, fs};
    else
      r = {8'hE5, r[15:8], fs, 2'h1, r[1], k[1]};
    if (k == 2'h3)
      r[23:20] = 4'h0;
    // word built first, so the decoder sees one clean change per edge
    @(negedge clk_in);
    instr_valid_in = 1'b1;
    addr_in        = a;
    instr_in       = r;
    if (k != 2'h0 && k != 2'h3 && a < store_unit_pkg::REG_WINDOW_LIMIT)
      exp_q.push_back({1'b1, 42'h0});
    else if (k != 2'h3)
      exp_q.push_back({2'h1, a, d, (k == 2'h0) ? 2'h3 : {~k[1], k[1]}});
  endtask

  task automatic idle();
    @(negedge clk_in);
    instr_valid_in = 1'b0;
    repeat (3) @(negedge clk_in);
  endtask

  always @(negedge clk_in)
    if (mem_wr_out.valid === 1'b1 || bus_fault_irq_out === 1'b1)
    begin
      if (exp_q.size() == 0)
        check(1'b0, "unexpected output");
      else if (exp_q[0][42])
        check(bus_fault_irq_out && !mem_wr_out.valid, "fault");
      else
        check({bus_fault_irq_out, mem_wr_out} === exp_q[0], "write");
      if (exp_q.size() != 0)
        void'(exp_q.pop_front());
    end

  initial
  begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  initial
  begin
    arst_n_in = 1'b0;
    instr_valid_in = 1'b0;
    instr_in = '0;
    addr_in = '0;
    foreach (aux_in[i]) aux_in[i] = 16'(rnd());
    foreach (tmp_in[i]) tmp_in[i] = 16'(rnd());
    acc_in = '{40'h2304006500, 40'h20FC006788, {8'h5A, rnd()}, {8'hA5, rnd()}};
    aux_in[0] = 16'h6903;
    repeat (5) @(negedge clk_in);
    arst_n_in = 1'b1;
    store(2'h0, 4'h8, 23'h200);
    store(2'h1, 4'h1, 23'h200);
    idle();
    check(rd_data === 16'h8803, "high lane");
    store(2'h2, 4'h0, 23'h200);
    idle();
    check(rd_data === 16'h8800, "low lane");
    store(2'h1, 4'hC, 23'h10);
    store(2'h2, 4'h8, 23'h5F);
    store(2'h2, 4'hD, 23'h60);
    idle();
    $display("directed stores done");
    repeat (300) store(2'(rnd()), 4'(rnd()), 23'(rnd() & 32'hFF));
    idle();
    check(exp_q.size() == 0, "missing output");
    $display("repeated stores done");
    test_done();
  end
endmodule
